// File: design/pwm_pkg.sv
// Constants, types and the register map of the standard PWM block.
// Assumes one 100 MHz system clock, the oscillator, driving all logic.
// Function
// - The PWM output selects which of the three 8-bit auto-reload timers gives its time base.
// - The period is the period register plus one, times four oscillator periods, times the prescale.
// - On the increment after the count equals the period register the timer clears, the pin goes high unless the duty is zero, and the duty is copied into the 10-bit buffer.
// - No postscaler takes part in setting the PWM period.
// - The duty is 10 bits across the high and low duty registers, left or right aligned by a format bit.
// - Duty writes are taken at any time but act only after the next period match loads the buffer.
// - The 10-bit time base is the 8-bit count plus two low bits, the clock phase at 1:1 and prescaler bits otherwise.
// - When the 10-bit time base equals the buffered duty the pin goes low.
// - A duty greater than the period leaves the pin unchanged, since no clearing match occurs.
// - Resolution is log2 of four times the period register plus one, ten bits at 255.
// - The high time is the duty times one oscillator period times the prescale.
// - The duty ratio is the duty over four times the period register plus one.
package pwm_pkg;

  localparam int NUM_TIMERS = 3;
  localparam int CNT_W = 8;
  localparam int DUTY_W = 10;
  localparam int LOW_W = DUTY_W - CNT_W;
  localparam int PRESC_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TCON_W = 3;
  localparam int SEL_W = 2;

  // Last oscillator phase of each four-period timer input tick
  localparam logic [LOW_W-1:0] PHASE_LAST = 2'h3;

  // Prescaler terminal counts
  localparam logic [PRESC_W-1:0] PRESC_LAST_4 = 6'h03;
  localparam logic [PRESC_W-1:0] PRESC_LAST_16 = 6'h0F;
  localparam logic [PRESC_W-1:0] PRESC_LAST_64 = 6'h3F;

  typedef enum logic [1:0] {PS_1, PS_4, PS_16, PS_64} prescale_t;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TCON0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD0 = 8'h04;
  localparam logic [ADDR_W-1:0] TIMER_STRIDE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MCTL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DUTY_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_DUTY_HI = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_TSEL_A = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h3C;

  // Field positions
  localparam int TCON_PS_LSB = 0;
  localparam int TCON_RUN_BIT = 2;
  localparam int MCTL_EN_BIT = 0;
  localparam int MCTL_FMT_BIT = 4;
  localparam int MCTL_DIR_BIT = 7;
  localparam int COUNT_OUT_BIT = 16;

  // Reset values
  localparam logic [CNT_W-1:0] PERIOD_RESET = 8'hFF;
  localparam logic [TCON_W-1:0] TCON_RESET = 3'h0;
  localparam logic [CNT_W-1:0] MCTL_RESET = 8'h80;
  localparam logic [CNT_W-1:0] DUTY_RESET = 8'h00;
  localparam logic [SEL_W-1:0] TSEL_RESET = 2'h0;

  // AHB-Lite encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : pwm_pkg

// File: design/time_base_if.sv
// Interface carrying one timer's 10-bit time base and period match.
// Assumes the producer and consumer share mclk.
`timescale 1ns/1ps
`default_nettype none
interface time_base_if;
  import pwm_pkg::*;
  logic [CNT_W-1:0] count;
  logic [LOW_W-1:0] low;
  logic match;
  modport src (output count, output low, output match);
  modport dst (input count, input low, input match);
endinterface : time_base_if
`default_nettype wire

// File: design/pwm_time_base.sv
// One 8-bit auto-reload timer with prescaler and period compare.
// Assumes run, prescale and period come from registers on mclk.
`timescale 1ns/1ps
`default_nettype none
module pwm_time_base
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration
  input wire logic run,
  input wire prescale_t prescale_select,
  input wire logic [CNT_W-1:0] period,
  // Time base out
  time_base_if.src tb
);

  logic [LOW_W-1:0] phase_q, phase_d;
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic match_q, match_d;
  logic [PRESC_W-1:0] limit;
  logic tick;
  logic inc;

  always_comb
  begin
    case (prescale_select)
      PS_4: limit = PRESC_LAST_4;
      PS_16: limit = PRESC_LAST_16;
      PS_64: limit = PRESC_LAST_64;
      default: limit = '0;
    endcase
    // Timer input is always the oscillator over four
    tick = run && (phase_q == PHASE_LAST);
    inc = tick && (presc_q >= limit);
    phase_d = run ? phase_q + 1'b1 : phase_q;
    presc_d = presc_q;
    if (tick)
    begin
      presc_d = (presc_q >= limit) ? '0 : presc_q + 1'b1;
    end
    count_d = count_q;
    // No postscaler: the match pulse is the raw reload
    match_d = inc && (count_q == period);
    if (inc)
    begin
      count_d = (count_q == period) ? '0 : count_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q <= '0;
      presc_q <= '0;
      count_q <= '0;
      match_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      presc_q <= presc_d;
      count_q <= count_d;
      match_q <= match_d;
    end
  end

  // Two low bits give four steps per count, hence 4*(PR+1) steps
  always_comb
  begin
    case (prescale_select)
      PS_4: tb.low = presc_q[1:0];
      PS_16: tb.low = presc_q[3:2];
      PS_64: tb.low = presc_q[5:4];
      default: tb.low = phase_q;
    endcase
  end

  assign tb.count = count_q;
  assign tb.match = match_q;

endmodule : pwm_time_base
`default_nettype wire

// File: design/ccp_standard_pwm.sv
// Standard PWM output with three selectable time bases and AHB-Lite
// register access. Assumes a single AHB-Lite master and one slave.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ccp_standard_pwm
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // PWM pin
  output logic pwm_out,
  output logic pwm_oe,
  // Interrupt
  output logic irq
);

  // Timer registers
  logic [NUM_TIMERS-1:0][CNT_W-1:0] period_q, period_d;
  logic [NUM_TIMERS-1:0][TCON_W-1:0] tcon_q, tcon_d;

  // Module registers
  logic [CNT_W-1:0] mctl_q, mctl_d;
  logic [CNT_W-1:0] duty_lo_q, duty_lo_d;
  logic [CNT_W-1:0] duty_hi_q, duty_hi_d;
  logic [SEL_W-1:0] tsel_q, tsel_d;
  logic [NUM_TIMERS-1:0] flag_q, flag_d;
  logic [NUM_TIMERS-1:0] en_q, en_d;
  logic irq_q, irq_d;

  // Bus state
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic hready_q, hready_d;
  logic [DATA_W-1:0] hrdata_q, hrdata_d;

  // PWM state
  logic [DUTY_W-1:0] buf_q, buf_d;
  logic pwm_q, pwm_d;
  logic oe_q, oe_d;

  // Time base taps
  logic [NUM_TIMERS-1:0][CNT_W-1:0] tb_count;
  logic [NUM_TIMERS-1:0][LOW_W-1:0] tb_low;
  logic [NUM_TIMERS-1:0] tb_match;

  logic take;
  logic wr_now;
  logic [SEL_W-1:0] sel;
  logic [DUTY_W-1:0] tb_now;
  logic match_now;
  logic [DUTY_W-1:0] duty_val;
  logic [DATA_W-1:0] rd_val;

  time_base_if tb [NUM_TIMERS] ();

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : gen_timer
      pwm_time_base u_time_base (
        .mclk(mclk),
        .arst_n(arst_n),
        .run(tcon_q[g][TCON_RUN_BIT]),
        .prescale_select(prescale_t'(tcon_q[g][TCON_PS_LSB +: 2])),
        .period(period_q[g]),
        .tb(tb[g].src)
      );
      assign tb_count[g] = tb[g].count;
      assign tb_low[g] = tb[g].low;
      assign tb_match[g] = tb[g].match;
    end
  endgenerate

  // Bus front end
  always_comb
  begin
    take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    wr_now = wr_pend_q && hready;
    wr_pend_d = wr_pend_q;
    rd_pend_d = rd_pend_q;
    addr_d = addr_q;
    hready_d = hready_q;
    hrdata_d = hrdata_q;
    if (wr_now)
    begin
      wr_pend_d = 1'b0;
    end
    if (rd_pend_q)
    begin
      // Wait cycle lets a write just before the read settle first
      hrdata_d = rd_val;
      hready_d = 1'b1;
      rd_pend_d = 1'b0;
    end
    if (take)
    begin
      addr_d = haddr[ADDR_W-1:0];
      if (hwrite)
      begin
        wr_pend_d = 1'b1;
      end
      else
      begin
        rd_pend_d = 1'b1;
        hready_d = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_val = '0;
    if (addr_q == OFS_MCTL)
    begin
      rd_val[CNT_W-1:0] = mctl_q;
    end
    else if (addr_q == OFS_DUTY_LO)
    begin
      rd_val[CNT_W-1:0] = duty_lo_q;
    end
    else if (addr_q == OFS_DUTY_HI)
    begin
      rd_val[CNT_W-1:0] = duty_hi_q;
    end
    else if (addr_q == OFS_TSEL_A)
    begin
      rd_val[SEL_W-1:0] = tsel_q;
    end
    else if (addr_q == OFS_STATUS)
    begin
      rd_val[NUM_TIMERS-1:0] = flag_q;
    end
    else if (addr_q == OFS_ENABLE)
    begin
      rd_val[NUM_TIMERS-1:0] = en_q;
    end
    else if (addr_q == OFS_COUNT)
    begin
      rd_val[DUTY_W-1:0] = tb_now;
      rd_val[COUNT_OUT_BIT] = pwm_q;
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (addr_q == OFS_TCON0 + TIMER_STRIDE * ADDR_W'(i))
        begin
          rd_val[TCON_W-1:0] = tcon_q[i];
        end
        if (addr_q == OFS_PERIOD0 + TIMER_STRIDE * ADDR_W'(i))
        begin
          rd_val[CNT_W-1:0] = period_q[i];
        end
      end
    end
  end

  // Register writes and interrupt flags
  always_comb
  begin
    period_d = period_q;
    tcon_d = tcon_q;
    mctl_d = mctl_q;
    duty_lo_d = duty_lo_q;
    duty_hi_d = duty_hi_q;
    tsel_d = tsel_q;
    en_d = en_q;
    flag_d = flag_q;
    if (wr_now)
    begin
      if (addr_q == OFS_MCTL)
      begin
        mctl_d = hwdata[CNT_W-1:0];
      end
      else if (addr_q == OFS_DUTY_LO)
      begin
        duty_lo_d = hwdata[CNT_W-1:0];
      end
      else if (addr_q == OFS_DUTY_HI)
      begin
        duty_hi_d = hwdata[CNT_W-1:0];
      end
      else if (addr_q == OFS_TSEL_A)
      begin
        tsel_d = hwdata[SEL_W-1:0];
      end
      else if (addr_q == OFS_CLEAR)
      begin
        flag_d = flag_q & ~hwdata[NUM_TIMERS-1:0];
      end
      else if (addr_q == OFS_ENABLE)
      begin
        en_d = hwdata[NUM_TIMERS-1:0];
      end
      else
      begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
          if (addr_q == OFS_TCON0 + TIMER_STRIDE * ADDR_W'(i))
          begin
            tcon_d[i] = hwdata[TCON_W-1:0];
          end
          if (addr_q == OFS_PERIOD0 + TIMER_STRIDE * ADDR_W'(i))
          begin
            period_d[i] = hwdata[CNT_W-1:0];
          end
        end
      end
    end
    // A match in the clearing cycle still sets its flag
    flag_d = flag_d | tb_match;
    irq_d = |(flag_q & en_q);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      period_q <= {NUM_TIMERS{PERIOD_RESET}};
      tcon_q <= {NUM_TIMERS{TCON_RESET}};
      mctl_q <= MCTL_RESET;
      duty_lo_q <= DUTY_RESET;
      duty_hi_q <= DUTY_RESET;
      tsel_q <= TSEL_RESET;
      en_q <= '0;
      flag_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      period_q <= period_d;
      tcon_q <= tcon_d;
      mctl_q <= mctl_d;
      duty_lo_q <= duty_lo_d;
      duty_hi_q <= duty_hi_d;
      tsel_q <= tsel_d;
      en_q <= en_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  // Waveform generation
  always_comb
  begin
    // Out-of-range selections fall back to the first timer
    sel = (tsel_q < SEL_W'(NUM_TIMERS)) ? tsel_q : '0;
    tb_now = {tb_count[sel], tb_low[sel]};
    match_now = tb_match[sel];
    if (mctl_q[MCTL_FMT_BIT])
    begin
      duty_val = {duty_hi_q, duty_lo_q[CNT_W-1 -: LOW_W]};
    end
    else
    begin
      duty_val = {duty_hi_q[LOW_W-1:0], duty_lo_q};
    end
    buf_d = buf_q;
    pwm_d = pwm_q;
    if (!mctl_q[MCTL_EN_BIT])
    begin
      pwm_d = 1'b0;
    end
    else if (match_now)
    begin
      buf_d = duty_val;
      pwm_d = (duty_val != '0);
    end
    else if (tb_now == buf_q)
    begin
      // Duty beyond 4*(PR+1) never matches, so the pin holds
      pwm_d = 1'b0;
    end
    // Driver stays off until software clears the direction bit
    oe_d = ~mctl_q[MCTL_DIR_BIT];
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buf_q <= '0;
      pwm_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      buf_q <= buf_d;
      pwm_q <= pwm_d;
      oe_q <= oe_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = HRESP_OKAY;
  assign pwm_out = pwm_q;
  assign pwm_oe = oe_q;
  assign irq = irq_q;

endmodule : ccp_standard_pwm
`default_nettype wire

// File: sim/pwm_sva.sv
// Bus timing and pin checks for the standard PWM block.
// Assumes a single AHB-Lite master whose hready is our hreadyout.
`timescale 1ns/1ps
`default_nettype none
module pwm_sva
  import pwm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pin and interrupt
  input wire logic pwm_out,
  input wire logic pwm_oe,
  input wire logic irq
);
  logic wr_take;
  logic rd_take;
  logic wr_dp_d;
  logic wr_dp_q;
  assign wr_take = hsel & htrans[1] & hready & hwrite;
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;
  always_comb wr_dp_d = wr_take;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      wr_dp_q <= 1'b0;
    else
      wr_dp_q <= wr_dp_d;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_write_no_wait: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_wait_from_read: assert property (!hreadyout |-> $past(rd_take))
    else $error("wait state without read");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(!hreadyout))
    else $error("read data changed outside a read");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  // Control lands one edge after the data phase, the enable one edge later
  a_oe_by_write: assert property (!$stable(pwm_oe) |-> $past(wr_dp_q, 2))
    else $error("driver enable moved without a write");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_dp_q, 2))
    else $error("interrupt dropped without a write");
  a_period_min: assert property ($rose(pwm_out) |=> (!$rose(pwm_out))[*3])
    else $error("pin period under four clocks");
  c_irq: cover property ($rose(irq));
endmodule : pwm_sva
bind ccp_standard_pwm pwm_sva u_sva (
  .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq)
);
`default_nettype wire

// File: sim/pwm_probe.sv
// Load on the PWM pin: counts high cycles and rise-to-rise spacing.
// Assumes a pull-down on the board line when the driver is off.
`timescale 1ns/1ps
`default_nettype none
module pwm_probe
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pin
  input wire logic pin,
  input wire logic oe,
  // Measurements
  output logic [31:0] high_n,
  output logic [31:0] gap
);
  logic line;
  logic prev;
  logic [31:0] cnt;
  // Released pin reads the pull-down, not the last driven level
  assign line = oe ? pin : 1'b0;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      high_n <= 32'h0;
      gap <= 32'h0;
      cnt <= 32'h0;
      prev <= 1'b0;
    end
    else
    begin
      prev <= line;
      high_n <= high_n + {31'h0, line};
      if (line && !prev)
      begin
        gap <= cnt;
        cnt <= 32'h1;
      end
      else
        cnt <= cnt + 32'h1;
    end
  end
endmodule : pwm_probe
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench: AHB-Lite master, random PWM setups, pin probe.
// Assumes one slave whose hreadyout is the bus hready; waits on it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pwm_pkg::*;
  logic mclk, arst_n, hsel, hwrite, hreadyout, hresp, pwm_out, pwm_oe, irq;
  logic [31:0] haddr, hwdata, hrdata, high_n, gap, seed, h0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int miscompares, n_compared;
  ccp_standard_pwm DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .irq(irq));
  pwm_probe u_probe (.mclk(mclk), .arst_n(arst_n), .pin(pwm_out),
    .oe(pwm_oe), .high_n(high_n), .gap(gap));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Duty beyond the period never meets a clearing match: high all period
  function automatic int exp_high(int d, int pr, int m);
    if (d >= 4 * (pr + 1))
      return 4 * (pr + 1) * m;
    return d * m;
  endfunction : exp_high
  task automatic chk(input logic [31:0] got, input logic [31:0] e,
    input string m);
    n_compared++;
    if (got !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, e);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input string m);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e, m);
  endtask : rdc
  task automatic wait_flag(input int t);
    logic [31:0] x;
    x = 32'h0;
    while (!x[t])
      xfer(1'b0, OFS_STATUS, 32'h0, x);
  endtask : wait_flag
  task automatic report_and_stop;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    int t, ps, pr, m, p, d;
    logic [7:0] tcon, per, lo, hi;
    logic fmt;
    {arst_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    seed = 32'h1CF72898;
    for (int k = 0; k < 6; k++)
    begin
      arst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      seed = xs(seed);
      t = seed % 3;
      ps = k % 4;
      pr = int'(seed[14:12]);
      m = 1 << (2 * ps);
      p = 4 * (pr + 1) * m;
      d = (k == 4) ? 0 : (k == 5) ? p / m + 1 : int'(seed[25:16]) % (p / m);
      fmt = seed[30];
      // Left aligned keeps the top eight duty bits in the high register
      hi = fmt ? 8'(d >> 2) : 8'(d >> 8);
      lo = fmt ? 8'(d << 6) : 8'(d);
      tcon = OFS_TCON0 + 8'(t) * TIMER_STRIDE;
      per = OFS_PERIOD0 + 8'(t) * TIMER_STRIDE;
      rdc(per, {24'h0, PERIOD_RESET}, "period reset");
      rdc(OFS_MCTL, {24'h0, MCTL_RESET}, "control reset");
      wr(8'h40, 32'hFFFFFFFF);
      rdc(8'h40, 32'h0, "unmapped read");
      wr(OFS_MCTL, 32'h80);
      wr(per, 32'(pr));
      wr(OFS_MCTL, 32'h81 | {27'h0, fmt, 4'h0});
      wr(OFS_DUTY_LO, {24'h0, lo});
      wr(OFS_DUTY_HI, {24'h0, hi});
      wr(OFS_CLEAR, 32'h7);
      wr(OFS_TSEL_A, 32'(t));
      wr(tcon, 32'(ps));
      wr(tcon, 32'(ps) | 32'h4);
      chk({31'h0, pwm_out}, 32'h0, "pin before first match");
      chk({31'h0, pwm_oe}, 32'h0, "driver off");
      wait_flag(t);
      wr(OFS_MCTL, 32'h1 | {27'h0, fmt, 4'h0});
      // Control lands at the data edge, the registered enable one edge later
      repeat (2) @(posedge mclk);
      chk({31'h0, pwm_oe}, 32'h1, "driver on");
      wr(OFS_CLEAR, 32'h1 << t);
      wait_flag(t);
      h0 = high_n;
      repeat (2 * p) @(posedge mclk);
      chk(high_n - h0, 32'(2 * exp_high(d, pr, m)), "high time");
      if (d != 0 && d < p / m)
        chk(gap, 32'(p), "pin period");
      wr(OFS_ENABLE, 32'h1 << t);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(OFS_ENABLE, 32'h0);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(tcon, 32'(ps));
      // A match launched just before the stop would win over the clear
      repeat (2) @(posedge mclk);
      wr(OFS_CLEAR, 32'h7);
      rdc(OFS_STATUS, 32'h0, "status cleared");
      wr(OFS_TSEL_A, 32'h3);
      rdc(OFS_TSEL_A, 32'h3, "select fallback readback");
      wr(OFS_ENABLE, 32'h7);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0, "irq idle");
      $display("test %0d done", k);
    end
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
